// ==== smram_decode_control.sv ====
// system management memory decode control: extended control and segment
// top registers, and routing of processor requests to dram or the link.
// assumes byte-wide config access by offset and single-cycle request strobes.
// Notes on behaviour
// - high window enabled only when global and high enable are both one
// - smm high window requests feda0000-fedbffff go to dram a0000-bffff
// - mono adapter bit six reads zero, read only, no decode effect
// - global enable exposes 128 KB at a0000 to smm requests
// - high window and top segment work only with global enable set
// - lock freezes high, global, size, segment enable and top fields
// - segment range accessible only to smm-flagged processor requests
// - non-smm requests into enabled segment go to the downstream link
// - segment mapped only when global and segment enable both set
// - four-bit top gives address bits 31:28; upper bits read zero
// - segment hit needs bits 39:32 zero and bottom <= addr < top
// - segment top resets to 1h
// - lock set by smm_space_lock_set_i pulse, cleared only by full reset
`timescale 1ns/1ps
module smram_decode_control (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic smm_space_lock_set_i,
  output logic smm_space_lock_o,
  input wire logic request_strobe_i,
  input wire logic [39:0] req_addr_i,
  input wire logic smm_request_flag_i,
  output logic resp_valid_o,
  output logic resp_to_link_o,
  output logic [39:0] resp_addr_o,
  output logic resp_smm_hit_o
);
  logic high_smram_enable_r;
  logic global_smram_enable_r;
  logic [1:0] top_segment_size_r;
  logic seg_enable_r;
  logic [3:0] protected_segment_top_r;
  logic smm_space_lock_r;
  logic wr_ctrl;
  logic wr_top;
  logic in_seg;
  logic high_on;
  logic seg_on;
  logic in_high;
  logic in_compat;
  logic to_link;
  logic smm_hit;
  logic [39:0] fwd_addr;

  assign wr_ctrl = cfg_wr_i && (cfg_addr_i == smram_decode_pkg::EXT_SMRAM_CONTROL_OFS);
  assign wr_top = cfg_wr_i && (cfg_addr_i == smram_decode_pkg::EXT_SMM_TOP_OFS);

  // lock: set by the smm_space_lock_set_i pulse, cleared only by reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      smm_space_lock_r <= 1'b0;
    end else if (smm_space_lock_set_i) begin
      smm_space_lock_r <= 1'b1;
    end
  end
  assign smm_space_lock_o = smm_space_lock_r;

  // control register fields, frozen once locked
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      high_smram_enable_r <= smram_decode_pkg::CONTROL_RESET[smram_decode_pkg::HIGH_EN_BIT];
      global_smram_enable_r <= smram_decode_pkg::CONTROL_RESET[smram_decode_pkg::GLOBAL_EN_BIT];
      top_segment_size_r <=
        smram_decode_pkg::CONTROL_RESET[smram_decode_pkg::SIZE_LSB +: 2];
      seg_enable_r <= smram_decode_pkg::CONTROL_RESET[smram_decode_pkg::SEG_EN_BIT];
    end else if (wr_ctrl && !smm_space_lock_r) begin
      high_smram_enable_r <= cfg_wdata_i[smram_decode_pkg::HIGH_EN_BIT];
      global_smram_enable_r <= cfg_wdata_i[smram_decode_pkg::GLOBAL_EN_BIT];
      top_segment_size_r <= cfg_wdata_i[smram_decode_pkg::SIZE_LSB +: 2];
      seg_enable_r <= cfg_wdata_i[smram_decode_pkg::SEG_EN_BIT];
    end
  end

  // segment top field, frozen once locked
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      protected_segment_top_r <= smram_decode_pkg::SEG_TOP_RESET;
    end else if (wr_top && !smm_space_lock_r) begin
      protected_segment_top_r <= cfg_wdata_i[3:0];
    end
  end

  // read data register; mono bit fixed, reserved bits zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (cfg_rd_i) begin
      case (cfg_addr_i)
        smram_decode_pkg::EXT_SMRAM_CONTROL_OFS: begin
          cfg_rdata_o <= {high_smram_enable_r, smram_decode_pkg::MONO_VALUE, 2'b00,
            global_smram_enable_r, top_segment_size_r, seg_enable_r};
        end
        smram_decode_pkg::EXT_SMM_TOP_OFS: begin
          cfg_rdata_o <= {4'h0, protected_segment_top_r};
        end
        default: begin
          cfg_rdata_o <= 8'h00;
        end
      endcase
    end
  end

  smram_seg_decode i_smram_seg_decode (
    .addr_i(req_addr_i),
    .seg_top_i(protected_segment_top_r),
    .seg_size_i(top_segment_size_r),
    .in_seg_o(in_seg)
  );

  // request decode
  always_comb begin
    high_on = global_smram_enable_r && high_smram_enable_r;
    seg_on = global_smram_enable_r && seg_enable_r;
    in_high = (req_addr_i >= smram_decode_pkg::HIGH_BASE)
      && (req_addr_i <= smram_decode_pkg::HIGH_LAST);
    in_compat = (req_addr_i >= smram_decode_pkg::COMPAT_BASE)
      && (req_addr_i <= smram_decode_pkg::COMPAT_LAST);
    to_link = 1'b1;
    smm_hit = 1'b0;
    fwd_addr = req_addr_i;
    if (seg_on && in_seg) begin
      to_link = !smm_request_flag_i;
      smm_hit = smm_request_flag_i;
    end else if (high_on && in_high && smm_request_flag_i) begin
      to_link = 1'b0;
      smm_hit = 1'b1;
      fwd_addr = req_addr_i - smram_decode_pkg::HIGH_TO_LOW_OFS;
    end else if (global_smram_enable_r && in_compat && smm_request_flag_i) begin
      to_link = 1'b0;
      smm_hit = 1'b1;
    end else if (in_high || in_compat) begin
      // ungranted window access goes to the link; a disabled segment stays dram
      to_link = 1'b1;
    end else begin
      to_link = 1'b0; // ordinary dram, outside protected windows
    end
  end

  // registered routing answer, one cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_to_link_o <= 1'b0;
      resp_addr_o <= 40'h00_0000_0000;
      resp_smm_hit_o <= 1'b0;
    end else begin
      resp_valid_o <= request_strobe_i;
      if (request_strobe_i) begin
        resp_to_link_o <= to_link;
        resp_addr_o <= fwd_addr;
        resp_smm_hit_o <= smm_hit;
      end
    end
  end

  // checks
  property p_lock_freeze;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    smm_space_lock_r |=> $stable(global_smram_enable_r) && $stable(protected_segment_top_r);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked field changed");

  property p_lock_sticky;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    smm_space_lock_r |=> smm_space_lock_r;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

  sequence s_seg_nonsmm;
    request_strobe_i && seg_on && in_seg && !smm_request_flag_i;
  endsequence
  property p_seg_nonsmm_link;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_seg_nonsmm |=> resp_valid_o && resp_to_link_o && !resp_smm_hit_o;
  endproperty
  a_seg_nonsmm_link: assert property (p_seg_nonsmm_link) else $error("segment leak");

  property p_seg_smm_dram;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && seg_on && in_seg && smm_request_flag_i |=> !resp_to_link_o;
  endproperty
  a_seg_smm_dram: assert property (p_seg_smm_dram) else $error("smm segment denied");

  property p_high_remap;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && high_on && in_high && smm_request_flag_i && !(seg_on && in_seg)
      |=> resp_addr_o == $past(req_addr_i) - smram_decode_pkg::HIGH_TO_LOW_OFS;
  endproperty
  a_high_remap: assert property (p_high_remap) else $error("high remap wrong");

  property p_high_needs_global;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && !global_smram_enable_r |=> !resp_smm_hit_o;
  endproperty
  a_high_needs_global: assert property (p_high_needs_global) else $error("hit w/o global");

  property p_mono_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cfg_rd_i && cfg_addr_i == smram_decode_pkg::EXT_SMRAM_CONTROL_OFS |=> !cfg_rdata_o[6];
  endproperty
  a_mono_zero: assert property (p_mono_zero) else $error("mono bit set");

  property p_top_upper_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cfg_rd_i && cfg_addr_i == smram_decode_pkg::EXT_SMM_TOP_OFS |=> cfg_rdata_o[7:4] == 4'h0;
  endproperty
  a_top_upper_zero: assert property (p_top_upper_zero) else $error("top upper nonzero");

  property p_above_4g;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    req_addr_i[39:32] != 8'h00 |-> !in_seg;
  endproperty
  a_above_4g: assert property (p_above_4g) else $error("segment hit above 4 GB");

  // reset values, with reset itself as the trigger
  property p_reset_lock;
    @(posedge ref_clk_i)
    !rst_n_i |=> !smm_space_lock_r;
  endproperty
  a_reset_lock: assert property (p_reset_lock) else $error("lock kept over reset");

  property p_reset_top;
    @(posedge ref_clk_i)
    !rst_n_i |=> protected_segment_top_r == smram_decode_pkg::SEG_TOP_RESET;
  endproperty
  a_reset_top: assert property (p_reset_top) else $error("segment top reset wrong");

  property p_reset_size;
    @(posedge ref_clk_i)
    !rst_n_i |=> top_segment_size_r
      == smram_decode_pkg::CONTROL_RESET[smram_decode_pkg::SIZE_LSB +: 2];
  endproperty
  a_reset_size: assert property (p_reset_size) else $error("size reset wrong");

  property p_lock_set;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    smm_space_lock_set_i |=> smm_space_lock_r;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");

  property p_lock_freeze_ctl;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    smm_space_lock_r |=> $stable(high_smram_enable_r) && $stable(top_segment_size_r)
      && $stable(seg_enable_r);
  endproperty
  a_lock_freeze_ctl: assert property (p_lock_freeze_ctl) else $error("field moved");

  property p_top_write;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_top && !smm_space_lock_r
      |=> {4'h0, protected_segment_top_r} == ($past(cfg_wdata_i) & 8'h0f);
  endproperty
  a_top_write: assert property (p_top_write) else $error("top write lost");

  // compatible window steps: smm request granted in place, others to the link
  sequence s_compat_smm;
    request_strobe_i && global_smram_enable_r && in_compat && smm_request_flag_i && !in_seg;
  endsequence
  property p_compat_grant;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_compat_smm |=> resp_smm_hit_o && !resp_to_link_o && resp_addr_o == $past(req_addr_i);
  endproperty
  a_compat_grant: assert property (p_compat_grant) else $error("compat denied");

  sequence s_compat_plain;
    request_strobe_i && in_compat && !in_seg && !smm_request_flag_i;
  endsequence
  property p_compat_plain;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_compat_plain |=> resp_to_link_o && !resp_smm_hit_o;
  endproperty
  a_compat_plain: assert property (p_compat_plain) else $error("compat leak");

  // a segment that is not enabled is ordinary dram
  sequence s_seg_off;
    request_strobe_i && in_seg && !seg_on && !in_high && !in_compat;
  endsequence
  property p_seg_off_dram;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_seg_off |=> !resp_to_link_o && !resp_smm_hit_o;
  endproperty
  a_seg_off_dram: assert property (p_seg_off_dram) else $error("segment off routed");

  // high window without both enables is never granted
  sequence s_high_off;
    request_strobe_i && in_high && !high_on && !(seg_on && in_seg);
  endsequence
  property p_high_off_link;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    s_high_off |=> resp_to_link_o && !resp_smm_hit_o;
  endproperty
  a_high_off_link: assert property (p_high_off_link) else $error("high off granted");

  property p_high_nonsmm;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && high_on && in_high && !smm_request_flag_i && !(seg_on && in_seg)
      |=> resp_to_link_o && resp_addr_o == $past(req_addr_i);
  endproperty
  a_high_nonsmm: assert property (p_high_nonsmm) else $error("high leak");

  property p_nonsmm_no_hit;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && !smm_request_flag_i |=> !resp_smm_hit_o;
  endproperty
  a_nonsmm_no_hit: assert property (p_nonsmm_no_hit) else $error("non-smm hit");

  property p_resp_pulse;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i |=> resp_valid_o;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("no response");

  property p_plain_dram;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    request_strobe_i && !in_seg && !in_high && !in_compat
      |=> !resp_to_link_o && !resp_smm_hit_o && resp_addr_o == $past(req_addr_i);
  endproperty
  a_plain_dram: assert property (p_plain_dram) else $error("plain access misrouted");
endmodule

// ==== smram_decode_control_tb_top.sv ====
// self-checking bench for the smram decode block with a queued scoreboard.
// assumes smram_host_model drives config accesses and requests.
`timescale 1ns/1ps
module smram_decode_control_tb_top;
  typedef struct packed {logic to_link; logic [39:0] addr; logic hit;} resp_s;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic lock_set = 1'b0;
  logic rd_d = 1'b0;
  logic wr, rd, stb, smm, lock_o, valid_o, link_o, hit_o;
  logic [7:0] ofs, wdata, rdata, ctl = 8'h00;
  logic [39:0] raddr, addr_o;
  logic [3:0] top = 4'h1;
  logic locked = 1'b0;
  resp_s rq[$];
  logic [7:0] dq[$];
  int miscompares = 0;
  int comparisons = 0;
  smram_host_model i_smram_host_model (.clk_i(ref_clk_i), .wr_o(wr), .rd_o(rd),
    .addr_o(ofs), .wdata_o(wdata), .strobe_o(stb), .req_addr_o(raddr), .smm_o(smm));
  smram_decode_control i_smram_decode_control (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(ofs), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .smm_space_lock_set_i(lock_set), .smm_space_lock_o(lock_o),
    .request_strobe_i(stb), .req_addr_i(raddr), .smm_request_flag_i(smm),
    .resp_valid_o(valid_o), .resp_to_link_o(link_o), .resp_addr_o(addr_o),
    .resp_smm_hit_o(hit_o));
  // clock generator
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if (!locked && a == 8'h62) ctl = d & 8'h8f;
    if (!locked && a == 8'h63) top = d[3:0];
    i_smram_host_model.cfg(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    dq.push_back(a == 8'h62 ? ctl : a == 8'h63 ? {4'h0, top} : 8'h00);
    i_smram_host_model.cfg(1'b0, a, 8'h00);
  endtask
  // expected route from the current control and top values
  function automatic resp_s predict(input logic [39:0] a, input logic s);
    logic [32:0] t;
    logic [32:0] b;
    t = {1'b0, top, 28'h0};
    b = t - (33'h8_0000 << ctl[2:1]);
    if (ctl[3] && ctl[0] && a[39:32] == 8'h00 && {1'b0, a[31:0]} >= b
        && {1'b0, a[31:0]} < t) return '{!s, a, s};
    if (ctl[3] && ctl[7] && a >= 40'hfeda0000 && a <= 40'hfedbffff)
      return s ? '{1'b0, a - 40'hfed00000, 1'b1} : '{1'b1, a, 1'b0};
    if (ctl[3] && a >= 40'ha0000 && a <= 40'hbffff) return '{!s, a, s};
    // window addresses that are not granted go to the link
    if ((a >= 40'hfeda0000 && a <= 40'hfedbffff) || (a >= 40'ha0000 && a <= 40'hbffff))
      return '{1'b1, a, 1'b0};
    return '{1'b0, a, 1'b0};
  endfunction
  task automatic req(input logic [39:0] a, input logic s);
    rq.push_back(predict(a, s));
    i_smram_host_model.req(a, s);
  endtask
  // monitor: pops the oldest note whenever a result appears
  always @(posedge ref_clk_i) begin
    rd_d <= rd;
    if (rd_d) check("cfg_rdata_o", 42'(rdata), 42'(dq.pop_front()));
    if (valid_o === 1'b1) check("resp_valid_o", 42'(rq.size() != 0), 42'h1);
    if (valid_o === 1'b1) check("resp", {link_o, addr_o, hit_o}, rq.pop_front());
  end
  // watchdog
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    logic [39:0] t;
    logic [39:0] al[12];
    void'($urandom(95340));
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    rd_reg(8'h62);
    rd_reg(8'h63);
    wr_reg(8'h62, 8'hff);
    rd_reg(8'h62);
    rd_reg(8'h5a);
    for (int i = 0; i < 32; i++) begin
      wr_reg(8'h62, {i[4], 3'($urandom()), i[3:0]});
      wr_reg(8'h63, {4'($urandom()), 4'(1 + $urandom_range(7))});
      rd_reg(8'h63);
      t = {8'h00, top, 28'h0};
      al = '{t - 1, t - (40'h8_0000 << ctl[2:1]), t - (40'h8_0000 << ctl[2:1]) - 1, t,
             40'hfeda0000, 40'hfedbffff, 40'hfedc0000, 40'ha0000, 40'hbffff, 40'hc0000,
             {8'h01, t[31:0] - 32'h1}, 40'($urandom())};
      for (int k = 0; k < 24; k++) req(al[k / 2], k[0]);
    end
    @(posedge ref_clk_i);
    #1 lock_set = 1'b1;
    @(posedge ref_clk_i);
    #1 lock_set = 1'b0;
    locked = 1'b1;
    check("lock", 42'(lock_o), 42'h1);
    wr_reg(8'h62, 8'h00);
    wr_reg(8'h63, 8'h02);
    rd_reg(8'h62);
    rd_reg(8'h63);
    req(t - 1, 1'b0);
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b0;
    {ctl, top, locked} = {8'h00, 4'h1, 1'b0};
    repeat (2) @(posedge ref_clk_i);
    #1 rst_n_i = 1'b1;
    check("lock", 42'(lock_o), 42'h0);
    wr_reg(8'h62, 8'h08);
    rd_reg(8'h62);
    rd_reg(8'h63);
    repeat (4) @(posedge ref_clk_i);
    check("leftover", 42'(rq.size() + dq.size()), 42'h0);
    conclude();
  end
endmodule

// ==== smram_decode_pkg.sv ====
// package for the system management memory decode block: register offsets,
// field positions, reset values and decode windows.
// assumes 8-bit configuration registers reached by byte offset.
package smram_decode_pkg;
  localparam logic [7:0] EXT_SMRAM_CONTROL_OFS = 8'h62;
  localparam logic [7:0] EXT_SMM_TOP_OFS = 8'h63;
  // control register field positions
  localparam int HIGH_EN_BIT = 7;
  localparam int MONO_BIT = 6;
  localparam int GLOBAL_EN_BIT = 3;
  localparam int SIZE_LSB = 1;
  localparam int SEG_EN_BIT = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] SEG_TOP_RESET = 4'h1;
  localparam logic MONO_VALUE = 1'b0;
  // address windows
  localparam logic [39:0] HIGH_BASE = 40'h00_feda_0000;
  localparam logic [39:0] HIGH_LAST = 40'h00_fedb_ffff;
  localparam logic [39:0] COMPAT_BASE = 40'h00_000a_0000;
  localparam logic [39:0] COMPAT_LAST = 40'h00_000b_ffff;
  localparam logic [39:0] HIGH_TO_LOW_OFS = 40'h00_fed0_0000;
  // segment size encodings as byte counts
  localparam logic [31:0] SEG_SIZE_00 = 32'h0008_0000;
  localparam logic [31:0] SEG_SIZE_01 = 32'h0010_0000;
  localparam logic [31:0] SEG_SIZE_10 = 32'h0020_0000;
  localparam logic [31:0] SEG_SIZE_11 = 32'h0040_0000;
  typedef enum logic [1:0] {ROUTE_DRAM, ROUTE_LINK} route_e;
endpackage

// ==== smram_host_model.sv ====
// host side model: configuration software and processor request issuer.
// assumes the block samples every input on the rising edge of clk_i.
`timescale 1ns/1ps
module smram_host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic strobe_o,
  output logic [39:0] req_addr_o,
  output logic smm_o
);
  // idle values at time zero
  initial begin
    {wr_o, rd_o, strobe_o, smm_o} = 4'h0;
    {addr_o, wdata_o} = 16'h0000;
    req_addr_o = 40'h00_0000_0000;
  end
  // one config access held over one edge; released lines show no stale value
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    {wr_o, rd_o} = 2'b00;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // one processor request with its smm flag
  task automatic req(input logic [39:0] a, input logic s);
    @(posedge clk_i);
    #1;
    strobe_o = 1'b1;
    req_addr_o = a;
    smm_o = s;
    @(posedge clk_i);
    #1;
    strobe_o = 1'b0;
    req_addr_o = ~a;
    smm_o = ~s;
  endtask
endmodule

// ==== smram_seg_decode.sv ====
// protected top segment range check for one request address.
// assumes a purely combinational path; caller registers results.
`timescale 1ns/1ps
module smram_seg_decode (
  input wire logic [39:0] addr_i,
  input wire logic [3:0] seg_top_i,
  input wire logic [1:0] seg_size_i,
  output logic in_seg_o
);
  // byte count of the segment for a size code
  function automatic logic [31:0] seg_bytes(input logic [1:0] code);
    case (code)
      2'b00: seg_bytes = smram_decode_pkg::SEG_SIZE_00;
      2'b01: seg_bytes = smram_decode_pkg::SEG_SIZE_01;
      2'b10: seg_bytes = smram_decode_pkg::SEG_SIZE_10;
      default: seg_bytes = smram_decode_pkg::SEG_SIZE_11;
    endcase
  endfunction
  logic [32:0] top;
  logic [32:0] bottom;
  // top sits on a 256 MB boundary; bottom is top minus the size
  always_comb begin
    top = {1'b0, seg_top_i, 28'h000_0000};
    bottom = top - {1'b0, seg_bytes(seg_size_i)};
    in_seg_o = (addr_i[39:32] == 8'h00) && ({1'b0, addr_i[31:0]} >= bottom)
      && ({1'b0, addr_i[31:0]} < top);
  end
endmodule
